// >>> hdl/mtf_unit.sv
// Memory test fault reporting and external access gating of the debug service unit.
// Assumes a march engine outside that reports faults and completion.
`include "mtf_regs.svh"

module mtf_unit
	import mtf_pkg::*;
#(
	parameter int ADDR_W = 30,
	parameter int BIT_W  = 5
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              resetn,
	// Register port
	input  wire logic [12:0]       reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	output logic      [31:0]       reg_rdata,
	// Protection state
	input  wire logic              protected_state,
	// March engine interface
	output logic                   test_start,
	output logic                   test_run,
	output logic                   test_abort,
	input  wire logic              test_fault,
	input  wire logic [ADDR_W-1:0] test_fault_loc,
	input  wire logic [BIT_W-1:0]  test_fault_bit,
	input  wire logic [2:0]        test_fault_phase,
	input  wire logic              test_finished,
	// CRC engine interface
	output logic                   crc_start,
	output logic                   crc_whole_area,
	output logic                   crc_eeprom_area,
	input  wire logic              crc_finished,
	input  wire logic              crc_bus_error,
	input  wire logic [31:0]       crc_value,
	// Processor reset extension
	input  wire logic              rstext_set,
	output logic                   cpu_reset_extension_flag
);

	// ------------------------------------------------------------
	// Address decoding
	// ------------------------------------------------------------
	wire logic        is_external = reg_addr >= `MTF_EXT_FIRST;
	wire logic        is_internal = reg_addr <= `MTF_INT_LAST;
	// Registers mirror into the external window at offset 0x200 and above
	wire logic [12:0] ofs         = is_external ? (reg_addr - `MTF_EXT_FIRST) : reg_addr;
	wire logic        mapped      = is_external || is_internal;
	wire logic [12:0] word_ofs    = {ofs[12:2], 2'b00};
	wire logic        wr          = reg_write && mapped;
	wire logic        rd          = reg_read && mapped;
	wire logic        wr_ctl      = wr && ofs == `MTF_OFS_CONTROL;
	wire logic        wr_fa       = wr && ofs == `MTF_OFS_FLAGS_A;
	wire logic        wr_loc      = wr && word_ofs == `MTF_OFS_START_LOC;
	wire logic        wr_len      = wr && word_ofs == `MTF_OFS_RANGE_SIZE;
	wire logic        wr_res      = wr && word_ofs == `MTF_OFS_RESULT;
	wire logic        wr_ch0      = wr && word_ofs == `MTF_OFS_CHAN_ZERO;
	wire logic        wr_ch1      = wr && word_ofs == `MTF_OFS_CHAN_ONE;
	wire logic        wr_cf0      = wr && word_ofs == `MTF_OFS_CONFIG_ZERO && !is_external;
	wire logic        wr_cf1      = wr && word_ofs == `MTF_OFS_CONFIG_ONE && !is_external;
	wire logic        rd_ch0      = rd && word_ofs == `MTF_OFS_CHAN_ZERO;
	wire logic        rd_ch1      = rd && word_ofs == `MTF_OFS_CHAN_ONE;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	mtf_state_type state_q, state_d;
	logic [31:0]   loc_q, len_q, res_q, ch0_q, ch1_q, cf0_q, cf1_q;
	logic          done_q, fail_q, bus_error_flag_q, protection_error_flag_q, rstext_q, ch0w_q, ch1w_q;
	logic          crc_busy_q;

	// ------------------------------------------------------------
	// Command decoding
	// ------------------------------------------------------------
	wire logic       soft_reset   = wr_ctl && reg_wdata[`MTF_CTL_SOFT_RESET_COMMAND];
	wire logic       bist_cmd     = wr_ctl && reg_wdata[`MTF_CTL_SELFTEST] && !soft_reset;
	// Self-test from outside is blocked while the part is protected
	wire logic       bist_blocked = bist_cmd && is_external && protected_state;
	wire logic       bist_go      = bist_cmd && !bist_blocked && state_q == MTF_IDLE;
	wire logic       crc_go       = wr_ctl && reg_wdata[`MTF_CTL_CRC] && !soft_reset && !crc_busy_q;
	wire logic [1:0] amode        = loc_q[1:0];
	// Clearing the reset extension from the external window is refused
	wire logic       rstext_clr   = wr_fa && reg_wdata[`MTF_FA_RSTEXT];
	wire logic       rstext_deny  = rstext_clr && is_external;
	wire logic       fail_w1c     = wr_fa && reg_wdata[`MTF_FA_FAIL];
	// Phase 0 writes only, so a fault tagged with it is ignored
	wire logic       fault_ok     = test_fault && test_fault_phase != MTF_PH_CLEAR;
	wire logic       fault_hit    = state_q == MTF_RUN && fault_ok;
	wire logic [31:0] fault_res   = {21'h000000, test_fault_phase, {(8 - BIT_W){1'b0}},
		// Phase 7 reports no usable bit index
		(test_fault_phase == MTF_PH_READ0) ? {BIT_W{1'b0}} : test_fault_bit};

	// ------------------------------------------------------------
	// Self-test sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			MTF_IDLE: begin
				if (bist_go)
					state_d = MTF_RUN;
			end
			MTF_RUN: begin
				if (fault_ok)
					state_d = (amode == 2'h1) ? MTF_PAUSE : MTF_IDLE;
				else if (test_finished)
					state_d = MTF_IDLE;
			end
			MTF_PAUSE: begin
				if (fail_w1c)
					state_d = MTF_RUN;
			end
			// Unused code falls back to idle
			default: state_d = MTF_IDLE;
		endcase
		if (soft_reset)
			state_d = MTF_IDLE;
	end

	always_ff @(posedge clock) begin
		if (!resetn)
			state_q <= MTF_IDLE;
		else
			state_q <= state_d;
	end

	// ------------------------------------------------------------
	// Status flags; hardware set wins over software clear, except soft reset and the start clear of done_q
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn || soft_reset) begin
			done_q <= 1'b0;
			fail_q <= 1'b0;
			bus_error_flag_q <= 1'b0;
			protection_error_flag_q <= 1'b0;
		end else begin
			if (bist_go || crc_go)
				done_q <= 1'b0;
			else if ((fault_hit && amode != 2'h1) || (state_q == MTF_RUN && test_finished) || crc_finished)
				done_q <= 1'b1;
			if (fault_hit)
				fail_q <= 1'b1;
			else if (bist_go || fail_w1c)
				fail_q <= 1'b0;
			if (crc_bus_error)
				bus_error_flag_q <= 1'b1;
			else if (crc_go)
				bus_error_flag_q <= 1'b0;
			if (bist_blocked || rstext_deny)
				protection_error_flag_q <= 1'b1;
			else if (wr_fa && reg_wdata[`MTF_FA_PROTERR])
				protection_error_flag_q <= 1'b0;
		end
	end

	// Reset extension survives soft reset; only hardware reset or an internal clear removes it
	always_ff @(posedge clock) begin
		if (!resetn)
			rstext_q <= 1'b0;
		else if (rstext_set)
			rstext_q <= 1'b1;
		else if (rstext_clr && !rstext_deny)
			rstext_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// Location, size and result registers
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn || soft_reset) begin
			loc_q <= 32'h00000000;
			len_q <= 32'h00000000;
			res_q <= 32'h00000000;
		end else if (fault_hit) begin
			// Capture held until a later fault, a checksum, a register write outside pause or soft reset
			loc_q <= {test_fault_loc, amode};
			res_q <= fault_res;
		end else if (crc_go && is_external) begin
			res_q <= `MTF_CRC_SEED;
		end else if (state_q == MTF_IDLE && crc_busy_q && crc_finished) begin
			res_q <= crc_value;
		end else if (state_q != MTF_PAUSE) begin
			// Writes during a paused fault would spoil the capture
			if (wr_loc)
				loc_q <= reg_wdata;
			if (wr_len)
				len_q <= reg_wdata;
			if (wr_res)
				res_q <= reg_wdata;
		end
	end

	// ------------------------------------------------------------
	// Debug channels with written flags, cleared on read
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			ch0_q  <= 32'h00000000;
			ch1_q  <= 32'h00000000;
			ch0w_q <= 1'b0;
			ch1w_q <= 1'b0;
			cf0_q  <= 32'h00000000;
			cf1_q  <= 32'h00000000;
		end else begin
			if (wr_ch0)
				ch0_q <= reg_wdata;
			if (wr_ch1)
				ch1_q <= reg_wdata;
			ch0w_q <= wr_ch0 || (ch0w_q && !rd_ch0);
			ch1w_q <= wr_ch1 || (ch1w_q && !rd_ch1);
			if (wr_cf0)
				cf0_q <= reg_wdata;
			if (wr_cf1)
				cf1_q <= reg_wdata;
		end
	end

	// ------------------------------------------------------------
	// Engine controls
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			test_start      <= 1'b0;
			test_run        <= 1'b0;
			test_abort      <= 1'b0;
			crc_start       <= 1'b0;
			crc_whole_area  <= 1'b0;
			crc_eeprom_area <= 1'b0;
			crc_busy_q      <= 1'b0;
		end else begin
			test_start <= bist_go;
			test_run   <= state_d == MTF_RUN;
			test_abort <= soft_reset;
			crc_start  <= crc_go;
			if (crc_go) begin
				// Outside callers get the whole area chosen by the mode field
				crc_whole_area  <= is_external;
				crc_eeprom_area <= is_external && amode == 2'h1;
			end
			if (crc_go)
				crc_busy_q <= 1'b1;
			else if (crc_finished || soft_reset)
				crc_busy_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Read data, valid one cycle after the strobe
	// ------------------------------------------------------------
	wire logic [31:0] flags_word = {8'h00,
		{4'h0, ch1w_q, ch0w_q, 1'b0, protected_state},
		{3'h0, protection_error_flag_q, fail_q, bus_error_flag_q, rstext_q, done_q}, 8'h00};
	logic [31:0] rdata_d;
	always_comb begin
		unique case (word_ofs)
			`MTF_OFS_CONTROL:     rdata_d = flags_word;
			`MTF_OFS_START_LOC:   rdata_d = loc_q;
			`MTF_OFS_RANGE_SIZE:  rdata_d = len_q;
			`MTF_OFS_RESULT:      rdata_d = res_q;
			`MTF_OFS_CHAN_ZERO:   rdata_d = ch0_q;
			`MTF_OFS_CHAN_ONE:    rdata_d = ch1_q;
			`MTF_OFS_IDENTITY:    rdata_d = `MTF_IDENTITY_VALUE;
			`MTF_OFS_CONFIG_ZERO: rdata_d = cf0_q;
			`MTF_OFS_CONFIG_ONE:  rdata_d = cf1_q;
			default:              rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!resetn)
			reg_rdata <= 32'h00000000;
		else if (rd)
			reg_rdata <= rdata_d;
		else
			reg_rdata <= 32'h00000000;
	end

	// Flag copy to the processor reset logic
	always_ff @(posedge clock) begin
		if (!resetn)
			cpu_reset_extension_flag <= 1'b0;
		else
			cpu_reset_extension_flag <= rstext_q;
	end

endmodule

// >>> hdl/mtf_regs.svh
// Register offsets, field positions, CRC seed and identity value of the memory test fault unit.
// Assumes byte offsets within the unit as seen on the plain register port.
`ifndef MTF_REGS_SVH
`define MTF_REGS_SVH

// Register offsets (byte addresses within the unit)
`define MTF_OFS_CONTROL     13'h0000
`define MTF_OFS_FLAGS_A     13'h0001
`define MTF_OFS_FLAGS_B     13'h0002
`define MTF_OFS_START_LOC   13'h0004
`define MTF_OFS_RANGE_SIZE  13'h0008
`define MTF_OFS_RESULT      13'h000C
`define MTF_OFS_CHAN_ZERO   13'h0010
`define MTF_OFS_CHAN_ONE    13'h0014
`define MTF_OFS_IDENTITY    13'h0018
`define MTF_OFS_CONFIG_ZERO 13'h00F0
`define MTF_OFS_CONFIG_ONE  13'h00F4

// Internal and external windows
`define MTF_INT_LAST        13'h0100
`define MTF_EXT_FIRST       13'h0200
`define MTF_EXT_LAST        13'h1FFF

// Control bits
`define MTF_CTL_SOFT_RESET_COMMAND       0
`define MTF_CTL_CRC         2
`define MTF_CTL_SELFTEST    3

// Flag register A bits
`define MTF_FA_DONE         0
`define MTF_FA_RSTEXT       1
`define MTF_FA_BUSERR       2
`define MTF_FA_FAIL         3
`define MTF_FA_PROTERR      4

// Flag register B bits
`define MTF_FB_CH0          2
`define MTF_FB_CH1          3

// Result word layout on a fault
`define MTF_RES_BIT_LSB     0
`define MTF_RES_PHASE_LSB   8

// Forced CRC seed for external starts
`define MTF_CRC_SEED        32'hFFFFFFFF
// Identity word; the value is arbitrary
`define MTF_IDENTITY_VALUE  32'h0000A5A5

`endif

// >>> hdl/mtf_pkg.sv
// Types shared by the memory test fault unit.
// Assumes nothing beyond a SystemVerilog compiler.
package mtf_pkg;
	// March phase codes
	typedef enum logic [2:0] {
		MTF_PH_CLEAR, MTF_PH_R0W1_UP, MTF_PH_R1W0, MTF_PH_R0W1_DN,
		MTF_PH_R1W0_DN, MTF_PH_R0W1, MTF_PH_R1W0_DN2, MTF_PH_READ0
	} mtf_phase_type;
	// Self-test sequencer states
	typedef enum logic [1:0] {MTF_IDLE, MTF_RUN, MTF_PAUSE} mtf_state_type;
endpackage

// >>> tb/mtf_unit_props.sv
// Port checker for the memory test fault unit.
// Assumes it is bound to mtf_unit and sees only that module's ports.
module mtf_unit_props (
	// Clock and reset
	input wire logic        clock,
	input wire logic        resetn,
	// Register port
	input wire logic [12:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [31:0] reg_rdata,
	// Engine side
	input wire logic        test_start,
	input wire logic        test_run,
	input wire logic        test_abort,
	input wire logic        test_fault,
	input wire logic [2:0]  test_fault_phase,
	input wire logic        test_finished,
	input wire logic        crc_start,
	input wire logic        crc_whole_area,
	input wire logic        cpu_reset_extension_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// Soft reset seen through either window
	wire soft_cmd = reg_write && reg_wdata[0] && (reg_addr == 13'h0000 || reg_addr == 13'h0200);
	wire hit_run  = test_run && test_fault;

	property p_start_cause; $rose(test_start) |-> $past(reg_write); endproperty
	property p_start_runs; test_start |-> test_run ##1 !test_start; endproperty
	property p_fault_halts; hit_run && test_fault_phase != 3'h0 |=> !test_run; endproperty
	property p_phase0; hit_run && test_fault_phase == 3'h0 && !reg_write && !test_finished |=> test_run; endproperty
	property p_finish; test_run && test_finished && !reg_write |=> !test_run; endproperty
	property p_abort; soft_cmd |=> test_abort; endproperty
	property p_ext_crc;
		reg_write && reg_addr == 13'h0200 && reg_wdata[2] && !reg_wdata[0] && !test_run |=> crc_start && crc_whole_area;
	endproperty
	property p_rstext; reg_write && reg_addr == 13'h0201 && reg_wdata[1] && cpu_reset_extension_flag |-> ##2 cpu_reset_extension_flag; endproperty
	property p_unmapped; reg_read && reg_addr > 13'h0100 && reg_addr < 13'h0200 |=> reg_rdata == 32'h00000000; endproperty

	a_start_cause: assert property (p_start_cause) else $error("start without a write");
	a_start_runs: assert property (p_start_runs) else $error("start pulse or run level wrong");
	a_fault_halts: assert property (p_fault_halts) else $error("run kept after a fault");
	a_phase0: assert property (p_phase0) else $error("clearing phase fault stopped the run");
	a_finish: assert property (p_finish) else $error("run kept after success");
	a_abort: assert property (p_abort) else $error("soft reset gave no abort");
	a_ext_crc: assert property (p_ext_crc) else $error("external checksum not whole area");
	a_rstext: assert property (p_rstext) else $error("external clear of reset extension taken");
	a_unmapped: assert property (p_unmapped) else $error("gap read returned data");

	// Main scenarios reached
	c_fault: cover property (hit_run && test_fault_phase != 3'h0);
	c_crc: cover property (crc_start);
	c_abort: cover property (test_abort);
endmodule

// >>> tb/mtf_engine_model.sv
// Stand-in for the march engine and the checksum engine.
// Assumes the bench sets the fault plan before each start.
module mtf_engine_model (
	// Clock and reset
	input wire logic        clock,
	input wire logic        resetn,
	// Plan from the bench
	input wire logic        arm,
	input wire logic [7:0]  delay,
	input wire logic [29:0] plan_loc,
	input wire logic [4:0]  plan_bit,
	input wire logic [2:0]  plan_phase,
	input wire logic [31:0] plan_crc,
	// Unit side
	input wire logic        test_start,
	input wire logic        test_run,
	input wire logic        crc_start,
	output logic            test_fault,
	output logic [29:0]     test_fault_loc,
	output logic [4:0]      test_fault_bit,
	output logic [2:0]      test_fault_phase,
	output logic            test_finished,
	output logic            crc_finished,
	output logic            crc_bus_error,
	output logic [31:0]     crc_value
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q;
	logic [2:0] crc_q;
	// Report lines toggle between reports, so a stale copy cannot pass
	always @(posedge clock) begin
		test_fault <= 1'b0;
		test_finished <= 1'b0;
		crc_bus_error <= crc_q[2] && plan_crc[0]; // Odd plans end with a bus error
		test_fault_loc <= ~test_fault_loc;
		test_fault_bit <= ~test_fault_bit;
		test_fault_phase <= ~test_fault_phase;
		crc_q <= {crc_q[1:0], crc_start};
		crc_finished <= crc_q[2];
		crc_value <= crc_q[2] ? plan_crc : ~crc_value;
		cnt_q <= (test_start || !resetn) ? 8'h00 : cnt_q + {7'h00, test_run};
		// One fault per run; the unit must stop on it unless it carries phase 0
		if (test_run && arm && cnt_q == delay) begin
			test_fault <= 1'b1;
			test_fault_loc <= plan_loc;
			test_fault_bit <= plan_bit;
			test_fault_phase <= plan_phase;
		end
		if (test_run && cnt_q == delay + 8'h06)
			test_finished <= 1'b1;
		if (!resetn) begin
			{test_fault_loc, test_fault_bit, test_fault_phase, crc_value, crc_q} <= 73'h0;
		end
	end
endmodule

// >>> tb/mtf_unit_test.sv
// Self-checking bench of the memory test fault unit.
// Assumes the engine model answers the unit's starts.
`include "mtf_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module mtf_unit_test import mtf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, resetn = 0, reg_write = 0, reg_read = 0, protected_state = 0, rstext_set = 0, arm = 0;
	logic [12:0] reg_addr = 13'h0000, base;
	logic [31:0] reg_wdata = 32'h0, plan_crc = 32'h0, rd_q, lfsr_q = 32'h00007C8D;
	logic [7:0] delay = 8'h04;
	logic [29:0] plan_loc = 30'h0, fl;
	logic [4:0] plan_bit = 5'h0, fb;
	logic [2:0] plan_phase = 3'h0, fp;
	logic [31:0] reg_rdata, crc_value;
	logic ts, tr, ta, tf, tfin, cs, cw, ce, cfin, cberr, cpu_reset_extension_flag;
	int miscompares = 0, checks = 0;
	always #5 clock = ~clock;
	mtf_unit uut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .protected_state(protected_state),
		.test_start(ts), .test_run(tr), .test_abort(ta), .test_fault(tf), .test_fault_loc(fl),
		.test_fault_bit(fb), .test_fault_phase(fp), .test_finished(tfin), .crc_start(cs),
		.crc_whole_area(cw), .crc_eeprom_area(ce), .crc_finished(cfin), .crc_bus_error(cberr),
		.crc_value(crc_value), .rstext_set(rstext_set), .cpu_reset_extension_flag(cpu_reset_extension_flag));
	mtf_engine_model partner (.clock(clock), .resetn(resetn), .arm(arm), .delay(delay), .plan_loc(plan_loc),
		.plan_bit(plan_bit), .plan_phase(plan_phase), .plan_crc(plan_crc), .test_start(ts), .test_run(tr),
		.crc_start(cs), .test_fault(tf), .test_fault_loc(fl), .test_fault_bit(fb), .test_fault_phase(fp),
		.test_finished(tfin), .crc_finished(cfin), .crc_bus_error(cberr), .crc_value(crc_value));
	// ----------------------------------------
	// Expectations and bus cycles
	// ----------------------------------------
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Bit index means nothing in the final read pass
	function automatic logic [31:0] exp_result(input logic [2:0] ph, input logic [4:0] b);
		return {21'h0, ph, 3'h0, (ph == 3'h7) ? 5'h00 : b};
	endfunction
	task automatic wr(input logic [12:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [12:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 rd_q = reg_rdata;
	endtask
	// Bounded poll of one flag bit
	task automatic wait_bit(input logic [12:0] a, input int b);
		int n = 0;
		rd(a);
		while (rd_q[b] !== 1'b1 && n < 60) begin
			rd(a);
			n++;
		end
		`CHK("completion", 1'b1, rd_q[b])
	endtask
	task automatic results;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		results();
	end
	initial begin
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		rd(13'h0000); `CHK("flags at reset", 32'h0, rd_q)
		rd(13'h0150); `CHK("gap read", 32'h0, rd_q)
		// Every phase code, odd ones through the external window
		for (int p = 0; p < 8; p++) begin
			lfsr_q = next_rand(lfsr_q);
			{plan_loc, plan_bit, plan_phase, delay, arm} <= {lfsr_q[29:0], lfsr_q[31:27], p[2:0], 5'h0, lfsr_q[2:0], 1'b1};
			base = p[0] ? 13'h0200 : 13'h0000;
			wr(base, 32'h1);
			wr(base + 13'h0004, {~lfsr_q[29:0], 2'b00});
			wr(base, 32'h8);
			wait_bit(base, 8);
			`CHK("fail flag", p != 0, rd_q[11])
			// A clearing-phase fault leaves the written location in place
			rd(base + 13'h0004);
			`CHK("location", {(p != 0) ? lfsr_q[29:0] : ~lfsr_q[29:0], 2'b00}, rd_q)
			rd(base + 13'h000C);
			if (p != 0) `CHK("result", exp_result(p[2:0], lfsr_q[31:27]), rd_q)
			else `CHK("no result", 32'h0, rd_q)
		end
		// Pause on fault, then resume
		lfsr_q = next_rand(lfsr_q);
		{plan_loc, plan_bit, plan_phase} <= {lfsr_q[29:0], lfsr_q[4:0], 3'h3};
		wr(13'h0000, 32'h1);
		wr(13'h0004, {lfsr_q[29:0], 2'b01});
		wr(13'h0000, 32'h8);
		wait_bit(13'h0000, 11);
		`CHK("done while paused", 1'b0, rd_q[8])
		`CHK("run while paused", 1'b0, tr)
		rd(13'h000C); `CHK("paused result", exp_result(3'h3, lfsr_q[4:0]), rd_q)
		wr(13'h0001, 32'h8);
		#1 `CHK("resumed", 1'b1, tr)
		wait_bit(13'h0000, 8);
		`CHK("fail after resume", 1'b0, rd_q[11])
		// External self-test while protected
		protected_state <= 1'b1;
		wr(13'h0000, 32'h1);
		wr(13'h0200, 32'h8);
		rd(13'h0200); `CHK("protection error", 1'b1, rd_q[12])
		`CHK("no start", 1'b0, tr)
		protected_state <= 1'b0;
		// Reset extension cleared only from inside
		rstext_set <= 1'b1;
		@(posedge clock);
		rstext_set <= 1'b0;
		wr(13'h0000, 32'h1);
		wr(13'h0201, 32'h2);
		rd(13'h0200); `CHK("ext kept", 2'b11, {rd_q[12], rd_q[9]})
		wr(13'h0001, 32'h2);
		repeat (2) @(posedge clock);
		#1 `CHK("int clear", 1'b0, cpu_reset_extension_flag)
		// External checksum over both areas, then one started from inside
		for (int m = 0; m < 3; m++) begin
			lfsr_q = next_rand(lfsr_q);
			plan_crc <= lfsr_q;
			wr(13'h0000, 32'h1);
			wr(13'h0004, m);
			wr((m == 2) ? 13'h0000 : 13'h0200, 32'h4);
			#1 `CHK("area", {m != 2, m == 1}, {cw, ce})
			// Seed is forced only for outside starts
			rd(13'h000C);
			`CHK("seed", (m != 2) ? `MTF_CRC_SEED : 32'h0, rd_q)
			wait_bit(13'h0000, 8);
			`CHK("bus error", lfsr_q[0], rd_q[10])
			rd(13'h000C); `CHK("checksum", lfsr_q, rd_q)
		end
		// Identity from outside; configuration writable only from inside
		rd(13'h0218);
		`CHK("identity", `MTF_IDENTITY_VALUE, rd_q)
		wr(13'h00F0, lfsr_q);
		wr(13'h02F0, ~lfsr_q);
		rd(13'h00F0);
		`CHK("config", lfsr_q, rd_q)
		// Channel zero from outside
		lfsr_q = next_rand(lfsr_q);
		wr(13'h0210, lfsr_q);
		rd(13'h0200); `CHK("written flag", 1'b1, rd_q[18])
		rd(13'h0210); `CHK("channel", lfsr_q, rd_q)
		rd(13'h0200); `CHK("flag after read", 1'b0, rd_q[18])
		results();
	end
endmodule
bind mtf_unit mtf_unit_props u_props (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.test_start(test_start), .test_run(test_run), .test_abort(test_abort), .test_fault(test_fault),
	.test_fault_phase(test_fault_phase), .test_finished(test_finished), .crc_start(crc_start),
	.crc_whole_area(crc_whole_area), .cpu_reset_extension_flag(cpu_reset_extension_flag));
